// ===== core/usb_audio_defines.svh
// Offsets, field positions, reset values and timing counts of the audio control block
`ifndef USB_AUDIO_DEFINES_SVH
`define USB_AUDIO_DEFINES_SVH

// ****
// Wishbone register byte offsets
// ****
`define REG_SETUP_LO 8'h00
`define REG_SETUP_HI 8'h04
`define REG_COMMAND 8'h08
`define REG_DESC_DATA 8'h0C
`define REG_DESC_PTR 8'h10
`define REG_VOLUME 8'h14
`define REG_STATE 8'h18
`define REG_KEY_REPORT 8'h1C

// ****
// Field positions
// ****
`define CMD_GO_BIT 0
`define CMD_DATA_LSB 16
`define STAT_DONE_BIT 0
`define STAT_STALL_BIT 1
`define STAT_RESP_LSB 16
`define DDATA_PKT_END_BIT 8
`define DDATA_LAST_BIT 9
`define DDATA_VALID_BIT 10
`define ST_MUTE_BIT 0
`define ST_KEYS_LSB 1
`define ST_SUSPEND_BIT 4
`define ST_FS_BIT 5
`define ST_ALT_PLAY_LSB 8
`define ST_ALT_REC_LSB 16
`define KR_NEW_BIT 8

// ****
// Reset values
// ****
`define RST_ATTEN 7'h00
`define RST_MUTE 1'b0
`define RST_ALT 5'h00

// ****
// Protocol constants
// ****
`define CTRL_PKT_BYTES 8
`define ATTEN_MAX_DB 64
`define ALT_MAX_PLAY 6
`define ALT_MAX_REC 18
`define FEATURE_UNIT_ID 8'h03
`define CS_MUTE 8'h01
`define CS_VOLUME 8'h02
`define DEVICE_DESC_LEN 8'h12
`define CONFIG_DESC_LEN 8'h50
`define LANG_DESC_LEN 8'h04

// ****
// Timing
// ****
`define CORE_CLK_KHZ 250000
`define SUSPEND_IDLE_MS 5
`define KEY_REPORT_MS 32
`define SUSPEND_IDLE_CYCLES (`SUSPEND_IDLE_MS * `CORE_CLK_KHZ)
`define KEY_REPORT_CYCLES (`KEY_REPORT_MS * `CORE_CLK_KHZ)

`endif

// ===== core/usb_audio_pkg.sv
// Types shared by the audio control block
package usb_audio_pkg;

  // Descriptor held in the response window
  typedef enum logic [1:0] {
    DESC_NONE = 2'b00,
    DESC_DEVICE = 2'b01,
    DESC_CONFIG = 2'b10,
    DESC_STRING = 2'b11
  } desc_kind_t;

  // Decoded control request
  typedef enum logic [2:0] {
    REQ_OTHER = 3'b000,
    REQ_GET_DESC = 3'b001,
    REQ_SET_IFACE = 3'b010,
    REQ_SET_CUR = 3'b011,
    REQ_GET_CUR = 3'b100
  } req_kind_t;

endpackage

// ===== core/volume_ramp.sv
// One channel of the attenuator ramp, one step per sample tick
`timescale 1ns/100ps
`include "usb_audio_defines.svh"
module volume_ramp #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Ramp control
  input wire logic step_tick,
  input wire logic [WIDTH-1:0] target,
  // Applied attenuation in dB
  output logic [WIDTH-1:0] level
);

  if (WIDTH < 7)
    $error("WIDTH cannot hold 64 dB");

  // ****
  // Ramp
  // ****
  // Single step per sample hides zipper noise on large changes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      level <= WIDTH'(`RST_ATTEN); // RULE25
    else if (step_tick && level < target)
      level <= level + WIDTH'(1); // RULE15
    else if (step_tick && level > target)
      level <= level - WIDTH'(1); // RULE15
  end

endmodule // volume_ramp

// ===== core/usb_audio_descriptor_volume_ctrl.sv
// Audio function identity, control requests, attenuator, keys and suspend
// What this block does
// RULE1 - Full speed only, pull-up always offered
// RULE2 - Device class, subclass, protocol all zero
// RULE3 - Control endpoint packet size eight bytes
// RULE4 - Vendor string 1, product 2, none serial
// RULE5 - IDs and strings are build-time parameters
// RULE6 - Four interfaces, bus powered, no wakeup
// RULE7 - Max power default 100 mA, changeable
// RULE8 - String zero gives US English only
// RULE9 - Two interfaces with selectable alternate settings
// RULE10 - Control interface accepts only setting zero
// RULE11 - Five entities with their terminal types
// RULE12 - Both stream terminals carry stereo left/right
// RULE13 - Feature unit offers only volume, mute
// RULE14 - Attenuation 0 to 64 dB, 1 dB steps
// RULE15 - Ramp one step per sample to target
// RULE16 - Separate targets and ramps per channel
// RULE17 - Master volume request stalled, nothing changes
// RULE18 - Mute master only, channel mute stalled
// RULE19 - Playback interface seven settings, zero idle
// RULE20 - Suspend output low suspended, high operating
// RULE21 - Keys active high, pulled down outside
// RULE22 - Keys only reported, never touch attenuator
// RULE23 - Key state reported every 32 ms
// RULE24 - Suspend after 5 ms idle, wake at once
// RULE25 - Reset gives 0 dB both, unmuted
// RULE26 - Descriptors from table, cut to length
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "usb_audio_defines.svh"
module usb_audio_descriptor_volume_ctrl #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678, // Arbitrary value
  parameter logic [7:0] MAX_POWER = 8'h32,
  parameter logic [127:0] VENDOR_STR = "Generic Audio",
  parameter int VENDOR_LEN = 13,
  parameter logic [127:0] PRODUCT_STR = "USB audio codec",
  parameter int PRODUCT_LEN = 15,
  parameter int unsigned SUSPEND_CYCLES = `SUSPEND_IDLE_CYCLES,
  parameter int unsigned REPORT_CYCLES = `KEY_REPORT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins from outside the clock domain
  input wire logic bus_idle_in,
  input wire logic fs_tick_in,
  input wire logic mute_key_in,
  input wire logic volume_up_key_in,
  input wire logic volume_down_key_in,
  // Bus state
  output logic suspend_flag_n,
  output logic fs_pullup_en,
  // Converter side
  output logic [6:0] left_atten,
  output logic [6:0] right_atten,
  output logic master_mute,
  output logic playback_stream_on,
  output logic record_stream_on,
  // Key report endpoint
  output logic [2:0] key_report,
  output logic key_report_strobe
);

  if (VENDOR_LEN < 1 || VENDOR_LEN > 16 || PRODUCT_LEN < 1 || PRODUCT_LEN > 16)
    $error("String length out of range");
  if (SUSPEND_CYCLES < 2 || SUSPEND_CYCLES > 24'hFFFFFF)
    $error("SUSPEND_CYCLES out of range");
  if (REPORT_CYCLES < 2 || REPORT_CYCLES > 24'hFFFFFF)
    $error("REPORT_CYCLES out of range");

  // ****
  // Descriptor tables
  // ****
  localparam logic [8*18-1:0] DEV_ROM = {
    8'h12, 8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08, // RULE2 RULE3
    VENDOR_ID[7:0], VENDOR_ID[15:8], PRODUCT_ID[7:0], PRODUCT_ID[15:8], // RULE5
    8'h00, 8'h01, 8'h01, 8'h02, 8'h00, 8'h01}; // RULE4
  localparam logic [8*80-1:0] CFG_ROM = {
    8'h09, 8'h02, 8'h50, 8'h00, 8'h04, 8'h01, 8'h00, 8'h80, MAX_POWER, // RULE6 RULE7
    8'h09, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, // RULE10
    8'h0A, 8'h24, 8'h01, 8'h00, 8'h01, 8'h3E, 8'h00, 8'h02, 8'h01, 8'h02,
    8'h0C, 8'h24, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, // RULE11 RULE12
    8'h09, 8'h24, 8'h03, 8'h02, 8'h01, 8'h03, 8'h00, 8'h03, 8'h00, // RULE11
    8'h0A, 8'h24, 8'h06, 8'h03, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h00, // RULE13
    8'h0C, 8'h24, 8'h02, 8'h04, 8'h01, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, // RULE11
    8'h09, 8'h24, 8'h03, 8'h05, 8'h01, 8'h01, 8'h00, 8'h04, 8'h00}; // RULE11 RULE12
  localparam logic [8*4-1:0] LANG_ROM = {8'h04, 8'h03, 8'h09, 8'h04}; // RULE8

  // UTF-16LE from a right-aligned ASCII parameter
  function automatic logic [7:0] str_byte(input logic [127:0] str, input int len,
                                          input logic [7:0] idx);
    int k;
    k = (int'(idx) - 2) / 2;
    if (idx == 8'h00)
      str_byte = 8'(2 + 2 * len);
    else if (idx == 8'h01)
      str_byte = 8'h03;
    else if (idx[0] == 1'b0 && k < len)
      str_byte = str[8*(len-1-k) +: 8];
    else
      str_byte = 8'h00;
  endfunction

  function automatic logic [7:0] desc_byte(input usb_audio_pkg::desc_kind_t kind,
                                           input logic [1:0] sidx, input logic [7:0] idx);
    desc_byte = 8'h00;
    case (kind)
      usb_audio_pkg::DESC_DEVICE:
        if (idx < `DEVICE_DESC_LEN)
          desc_byte = DEV_ROM[8*(17-int'(idx)) +: 8];
      usb_audio_pkg::DESC_CONFIG:
        if (idx < `CONFIG_DESC_LEN)
          desc_byte = CFG_ROM[8*(79-int'(idx)) +: 8];
      usb_audio_pkg::DESC_STRING:
        if (sidx == 2'd0 && idx < `LANG_DESC_LEN)
          desc_byte = LANG_ROM[8*(3-int'(idx)) +: 8];
        else if (sidx == 2'd1)
          desc_byte = str_byte(VENDOR_STR, VENDOR_LEN, idx);
        else if (sidx == 2'd2)
          desc_byte = str_byte(PRODUCT_STR, PRODUCT_LEN, idx);
      default:
        desc_byte = 8'h00;
    endcase
  endfunction

  // ****
  // Pin synchronisers
  // ****
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic fs_tick_prev;
  logic sample_tick;
  logic bus_idle;
  logic [2:0] keys;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      fs_tick_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {bus_idle_in, fs_tick_in, volume_down_key_in, volume_up_key_in,
                   mute_key_in}; // RULE21
      pin_sync <= pin_meta;
      fs_tick_prev <= pin_sync[3];
    end
  end

  assign keys = pin_sync[2:0];
  assign bus_idle = pin_sync[4];
  assign sample_tick = pin_sync[3] & ~fs_tick_prev;

  // ****
  // Wishbone access
  // ****
  logic [31:0] setup_lo;
  logic [31:0] setup_hi;
  logic [15:0] resp_value;
  logic cmd_done;
  logic cmd_stall;
  usb_audio_pkg::desc_kind_t resp_kind;
  logic [1:0] resp_sidx;
  logic [7:0] resp_len;
  logic [7:0] desc_ptr;
  logic [6:0] left_target;
  logic [6:0] right_target;
  logic [4:0] alt_play;
  logic [4:0] alt_rec;
  logic key_new;
  logic bus_req;
  logic wr_now;
  logic rd_now;
  logic [31:0] next_dat;
  logic [7:0] cur_byte;

  assign bus_req = cyc_i & stb_i;
  assign wr_now = bus_req & ack_o & we_i;
  assign rd_now = bus_req & ack_o & ~we_i;
  assign cur_byte = desc_byte(resp_kind, resp_sidx, desc_ptr);

  always_comb
  begin
    next_dat = 32'h00000000;
    if (adr_i == `REG_SETUP_LO)
      next_dat = setup_lo;
    else if (adr_i == `REG_SETUP_HI)
      next_dat = setup_hi;
    else if (adr_i == `REG_COMMAND)
      next_dat = {resp_value, 14'h0000, cmd_stall, cmd_done};
    else if (adr_i == `REG_DESC_DATA && desc_ptr < resp_len)
    begin
      next_dat[7:0] = cur_byte; // RULE26
      next_dat[`DDATA_PKT_END_BIT] = (desc_ptr[2:0] == 3'(`CTRL_PKT_BYTES - 1)); // RULE3
      next_dat[`DDATA_LAST_BIT] = (desc_ptr == resp_len - 8'h01);
      next_dat[`DDATA_VALID_BIT] = 1'b1;
    end
    else if (adr_i == `REG_DESC_PTR)
      next_dat = {16'h0000, resp_len, desc_ptr};
    else if (adr_i == `REG_VOLUME)
      next_dat = {1'b0, right_target, 1'b0, left_target, 1'b0, right_atten, 1'b0, left_atten};
    else if (adr_i == `REG_STATE)
      next_dat = {11'h000, alt_rec, 3'h0, alt_play, 2'h0, fs_pullup_en, ~suspend_flag_n,
                  keys, master_mute};
    else if (adr_i == `REG_KEY_REPORT)
      next_dat = {23'h000000, key_new, 5'h00, key_report};
  end

  // Answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= bus_req & ~ack_o;
      dat_o <= (bus_req & ~ack_o & ~we_i) ? next_dat : 32'h00000000;
    end
  end

  // Lanes left clear keep their old byte
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_merge = (wr & m) | (old & ~m);
  endfunction

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_lo <= 32'h00000000;
      setup_hi <= 32'h00000000;
    end
    else if (wr_now && adr_i == `REG_SETUP_LO)
      setup_lo <= lane_merge(setup_lo, dat_i, sel_i);
    else if (wr_now && adr_i == `REG_SETUP_HI)
      setup_hi <= lane_merge(setup_hi, dat_i, sel_i);
  end

  // ****
  // Control request execution
  // ****
  logic [7:0] rq_type;
  logic [7:0] rq_code;
  logic [15:0] rq_value;
  logic [15:0] rq_index;
  logic [15:0] rq_length;
  logic [15:0] cmd_data;
  logic go;
  logic to_fu;
  usb_audio_pkg::req_kind_t rq_kind;
  logic [7:0] str_len;

  assign rq_type = setup_lo[7:0];
  assign rq_code = setup_lo[15:8];
  assign rq_value = setup_lo[31:16];
  assign rq_index = setup_hi[15:0];
  assign rq_length = setup_hi[31:16];
  assign cmd_data = dat_i[31:16];
  assign go = wr_now && adr_i == `REG_COMMAND && sel_i[0] && dat_i[`CMD_GO_BIT];
  assign to_fu = rq_index == {`FEATURE_UNIT_ID, 8'h00};
  assign str_len = (rq_value[7:0] == 8'h00) ? `LANG_DESC_LEN :
                   (rq_value[7:0] == 8'h01) ? 8'(2 + 2 * VENDOR_LEN) : 8'(2 + 2 * PRODUCT_LEN);

  always_comb
  begin
    if (rq_type == 8'h80 && rq_code == 8'h06)
      rq_kind = usb_audio_pkg::REQ_GET_DESC;
    else if (rq_type == 8'h01 && rq_code == 8'h0B)
      rq_kind = usb_audio_pkg::REQ_SET_IFACE;
    else if (rq_type == 8'h21 && rq_code == 8'h01 && to_fu)
      rq_kind = usb_audio_pkg::REQ_SET_CUR;
    else if (rq_type == 8'hA1 && rq_code == 8'h81 && to_fu)
      rq_kind = usb_audio_pkg::REQ_GET_CUR;
    else
      rq_kind = usb_audio_pkg::REQ_OTHER;
  end

  // Host volume is signed 1/256 dB; positive gain clamps to 0 dB
  function automatic logic [6:0] vol_to_att(input logic [15:0] v);
    logic [15:0] neg;
    neg = 16'h0000 - v;
    if (!v[15])
      vol_to_att = 7'h00;
    else if (neg[15:8] >= 8'(`ATTEN_MAX_DB))
      vol_to_att = 7'(`ATTEN_MAX_DB); // RULE14
    else
      vol_to_att = neg[14:8]; // RULE14
  endfunction

  // Master volume and per-channel mute are stalled with nothing stored
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_done <= 1'b0;
      cmd_stall <= 1'b0;
      resp_value <= 16'h0000;
      resp_kind <= usb_audio_pkg::DESC_NONE;
      resp_sidx <= 2'd0;
      resp_len <= 8'h00;
      left_target <= `RST_ATTEN; // RULE25
      right_target <= `RST_ATTEN; // RULE25
      master_mute <= `RST_MUTE; // RULE25
      alt_play <= `RST_ALT;
      alt_rec <= `RST_ALT;
    end
    else if (go)
    begin
      cmd_done <= 1'b1;
      cmd_stall <= 1'b0;
      case (rq_kind)
        usb_audio_pkg::REQ_GET_DESC:
        begin
          resp_len <= 8'h00;
          if (rq_value[15:8] == 8'h01)
          begin
            resp_kind <= usb_audio_pkg::DESC_DEVICE;
            resp_len <= (rq_length < 16'(`DEVICE_DESC_LEN)) ? rq_length[7:0] : `DEVICE_DESC_LEN; // RULE26
          end
          else if (rq_value[15:8] == 8'h02)
          begin
            resp_kind <= usb_audio_pkg::DESC_CONFIG;
            resp_len <= (rq_length < 16'(`CONFIG_DESC_LEN)) ? rq_length[7:0] : `CONFIG_DESC_LEN; // RULE26
          end
          else if (rq_value[15:8] == 8'h03 && rq_value[7:0] < 8'h03)
          begin
            resp_kind <= usb_audio_pkg::DESC_STRING;
            resp_sidx <= rq_value[1:0]; // RULE4
            resp_len <= (rq_length < 16'(str_len)) ? rq_length[7:0] : str_len; // RULE26
          end
          else
          begin
            resp_kind <= usb_audio_pkg::DESC_NONE;
            cmd_stall <= 1'b1;
          end
        end
        usb_audio_pkg::REQ_SET_IFACE:
          if (rq_index == 16'h0001 && rq_value <= 16'(`ALT_MAX_PLAY))
            alt_play <= rq_value[4:0]; // RULE9 RULE19
          else if (rq_index == 16'h0002 && rq_value <= 16'(`ALT_MAX_REC))
            alt_rec <= rq_value[4:0]; // RULE9
          else if (!((rq_index == 16'h0000 || rq_index == 16'h0003) && rq_value == 16'h0000))
            cmd_stall <= 1'b1; // RULE10
        usb_audio_pkg::REQ_SET_CUR:
          if (rq_value == {`CS_MUTE, 8'h00})
            master_mute <= cmd_data[0]; // RULE18
          else if (rq_value == {`CS_VOLUME, 8'h01})
            left_target <= vol_to_att(cmd_data); // RULE16
          else if (rq_value == {`CS_VOLUME, 8'h02})
            right_target <= vol_to_att(cmd_data); // RULE16
          else
            cmd_stall <= 1'b1; // RULE13 RULE17 RULE18
        usb_audio_pkg::REQ_GET_CUR:
          if (rq_value == {`CS_MUTE, 8'h00})
            resp_value <= {15'h0000, master_mute};
          else if (rq_value == {`CS_VOLUME, 8'h01})
            resp_value <= 16'h0000 - {1'b0, left_target, 8'h00};
          else if (rq_value == {`CS_VOLUME, 8'h02})
            resp_value <= 16'h0000 - {1'b0, right_target, 8'h00};
          else
            cmd_stall <= 1'b1; // RULE17 RULE18
        default:
          cmd_stall <= 1'b1;
      endcase
    end
  end

  // Pointer restarts on every command; reads of the data window advance it
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      desc_ptr <= 8'h00;
    else if (go)
      desc_ptr <= 8'h00;
    else if (wr_now && adr_i == `REG_DESC_PTR && sel_i[0])
      desc_ptr <= dat_i[7:0];
    else if (rd_now && adr_i == `REG_DESC_DATA && desc_ptr < resp_len)
      desc_ptr <= desc_ptr + 8'h01; // RULE26
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      playback_stream_on <= 1'b0;
      record_stream_on <= 1'b0;
      fs_pullup_en <= 1'b0;
    end
    else
    begin
      playback_stream_on <= alt_play != 5'h00; // RULE19
      record_stream_on <= alt_rec != 5'h00;
      fs_pullup_en <= 1'b1; // RULE1
    end
  end

  // ****
  // Attenuator ramps
  // ****
  volume_ramp #(.WIDTH(7)) u_left_ramp (
    .core_clk(core_clk),
    .rstn(rstn),
    .step_tick(sample_tick), // RULE15
    .target(left_target),
    .level(left_atten)
  );

  volume_ramp #(.WIDTH(7)) u_right_ramp (
    .core_clk(core_clk),
    .rstn(rstn),
    .step_tick(sample_tick), // RULE15
    .target(right_target),
    .level(right_atten)
  );

  // ****
  // Key report
  // ****
  logic [23:0] report_count;

  // Keys feed only the report path and the state register, not the targets or mute
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      report_count <= 24'h000000;
      key_report <= 3'h0;
      key_report_strobe <= 1'b0;
      key_new <= 1'b0;
    end
    else
    begin
      key_report_strobe <= 1'b0;
      if (report_count == 24'(REPORT_CYCLES - 1))
      begin
        report_count <= 24'h000000;
        key_report <= keys; // RULE22 RULE23
        key_report_strobe <= 1'b1; // RULE23
        key_new <= 1'b1;
      end
      else
      begin
        report_count <= report_count + 24'h000001;
        if (rd_now && adr_i == `REG_KEY_REPORT)
          key_new <= 1'b0;
      end
    end
  end

  // ****
  // Suspend detect
  // ****
  logic [23:0] idle_count;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_count <= 24'h000000;
      suspend_flag_n <= 1'b1;
    end
    else if (!bus_idle)
    begin
      idle_count <= 24'h000000;
      suspend_flag_n <= 1'b1; // RULE20 RULE24
    end
    else if (idle_count == 24'(SUSPEND_CYCLES - 1))
      suspend_flag_n <= 1'b0; // RULE20 RULE24
    else
      idle_count <= idle_count + 24'h000001;
  end

endmodule // usb_audio_descriptor_volume_ctrl

// ===== testbench/audio_ctrl_checker.sv
// Port-level checks for the audio control block
`timescale 1ns/100ps
module audio_ctrl_checker #(
  parameter int unsigned REPORT_CYCLES = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Pins
  input wire logic bus_idle_in,
  input wire logic suspend_flag_n,
  input wire logic fs_pullup_en,
  input wire logic [6:0] left_atten,
  input wire logic [6:0] right_atten,
  input wire logic key_report_strobe
);
  // ****
  // Assertions
  // ****
  logic [31:0] gap;
  logic seen;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // First report has no reference, so gap is judged from the second on
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap <= 32'h0;
      seen <= 1'b0;
    end
    else
    begin
      gap <= key_report_strobe ? 32'h1 : gap + 32'h1;
      seen <= seen | key_report_strobe;
    end
  end
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_req; $rose(cyc_i && stb_i) |=> ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack late");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_range; left_atten <= 7'h40 && right_atten <= 7'h40; endproperty
  a_range: assert property (p_range) else $error("atten range");
  property p_lstep;
    !$stable(left_atten) |-> left_atten == $past(left_atten) + 7'h01 ||
      left_atten == $past(left_atten) - 7'h01;
  endproperty
  a_lstep: assert property (p_lstep) else $error("left step");
  property p_rstep;
    !$stable(right_atten) |-> right_atten == $past(right_atten) + 7'h01 ||
      right_atten == $past(right_atten) - 7'h01;
  endproperty
  a_rstep: assert property (p_rstep) else $error("right step");
  property p_wake; !bus_idle_in [*4] |-> suspend_flag_n; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_sleep; $fell(suspend_flag_n) |-> $past(bus_idle_in, 3); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep while busy");
  property p_pullup; $past(fs_pullup_en) |-> fs_pullup_en; endproperty
  a_pullup: assert property (p_pullup) else $error("pullup dropped");
  property p_gap; key_report_strobe && seen |-> gap == REPORT_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("report period");
  c_report: cover property (key_report_strobe && seen);
  c_sleep: cover property ($fell(suspend_flag_n));
  c_ramp: cover property (left_atten == 7'h0A);
endmodule // audio_ctrl_checker
bind usb_audio_descriptor_volume_ctrl audio_ctrl_checker #(.REPORT_CYCLES(REPORT_CYCLES)) u_chk (
  .core_clk, .rstn, .cyc_i, .stb_i, .ack_o, .dat_o, .bus_idle_in, .suspend_flag_n,
  .fs_pullup_en, .left_atten, .right_atten, .key_report_strobe);

// ===== testbench/far_side_model.sv
// Line state, sample clock and key pins seen from outside
`timescale 1ns/100ps
module far_side_model (
  // Clock
  input wire logic core_clk,
  // Controls
  input wire logic idle_req,
  input wire logic tick_en,
  input wire logic [2:0] press,
  // Pins
  output logic bus_idle = 1'b0,
  output logic fs_tick = 1'b0,
  output logic [2:0] keys
);
  logic [2:0] div = 3'h0;
  // Sample tick every eight cycles
  always @(posedge core_clk)
  begin
    div <= div + 3'h1;
    fs_tick <= tick_en & div[2];
    bus_idle <= idle_req;
  end
  // Pressed drives high, pull-down otherwise
  assign keys = press;
endmodule // far_side_model

// ===== testbench/tb.sv
// Self-checking bench for the audio control block
`timescale 1ns/100ps
`include "usb_audio_defines.svh"
module tb;
  // ****
  // Bench
  // ****
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic idle_req = 1'b0;
  logic tick_en = 1'b0;
  logic [2:0] press = 3'h0;
  logic ack_o, bus_idle_in, fs_tick_in, suspend_flag_n, fs_pullup_en, master_mute;
  logic playback_stream_on, record_stream_on, key_report_strobe;
  logic [6:0] left_atten, right_atten;
  logic [2:0] keys, key_report;
  logic [31:0] dat_o, q, e;
  int n_mismatch = 0;
  int n_tests = 0;
  int i, k, b, n;
  logic [7:0] tbl [31] = '{8'h12, 8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08, 8'h34,
    8'h12, 8'h78, 8'h56, 8'h00, 8'h01, 8'h01, 8'h02, 8'h00, 8'h01, 8'h09, 8'h02, 8'h50,
    8'h00, 8'h04, 8'h01, 8'h00, 8'h80, 8'h32, 8'h04, 8'h03, 8'h09, 8'h04};
  logic [31:0] sc [4] = '{32'h0201F600, 32'h0202BA00, 32'h02008000, 32'h01010001};
  logic [15:0] sif [7] = '{16'h1001, 16'h1107, 16'h0106, 16'h0212, 16'h1213, 16'h1301,
    16'h0100};
  always #2 core_clk = ~core_clk;
  usb_audio_descriptor_volume_ctrl #(.SUSPEND_CYCLES(20), .REPORT_CYCLES(16)) dut (
    .core_clk, .rstn, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .bus_idle_in, .fs_tick_in, .mute_key_in(keys[0]), .volume_up_key_in(keys[1]),
    .volume_down_key_in(keys[2]), .suspend_flag_n, .fs_pullup_en, .left_atten,
    .right_atten, .master_mute, .playback_stream_on, .record_stream_on, .key_report,
    .key_report_strobe);
  far_side_model host (.core_clk, .idle_req, .tick_en, .press, .bus_idle(bus_idle_in),
    .fs_tick(fs_tick_in), .keys);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (ack_o !== 1'b1 && t < 40);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (t >= 40)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic req(input logic [31:0] lo, input logic [31:0] hi, input logic [15:0] d);
    wb(1'b1, `REG_SETUP_LO, lo);
    wb(1'b1, `REG_SETUP_HI, hi);
    wb(1'b1, `REG_COMMAND, {d, 16'h0001});
    wb(1'b0, `REG_COMMAND, 32'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    wb(1'b0, `REG_VOLUME, 32'h0);
    chk("volume", q, 32'h0);
    wb(1'b0, `REG_STATE, 32'h0);
    chk("state", q, 32'h20);
    b = 0;
    for (k = 0; k < 3; k++)
    begin
      n = (k == 0) ? 18 : (k == 1) ? 9 : 4;
      req({8'(k + 1), 24'h000680}, {16'(n), 16'h0000}, 16'h0000);
      for (i = 0; i <= n; i++)
      begin
        wb(1'b0, `REG_DESC_DATA, 32'h0);
        e = (i == n) ? 32'h0 : {21'h0, 1'b1, i == n - 1, i % 8 == 7, tbl[b + i]};
        chk("desc", q, e);
      end
      b += n;
    end
    req(32'h03010680, 32'h00010000, 16'h0000);
    wb(1'b0, `REG_DESC_DATA, 32'h0);
    chk("vendor", q, 32'h61C);
    $display("descriptor test done");
    press <= 3'h7;
    for (k = 0; k < 4; k++)
    begin
      req({sc[k][31:16], 16'h0121}, 32'h00020300, sc[k][15:0]);
      chk("set cur", q[1:0], (k < 2) ? 2'b01 : 2'b11);
    end
    wb(1'b0, `REG_VOLUME, 32'h0);
    chk("targets", q, 32'h400A0000);
    tick_en <= 1'b1;
    i = 0;
    do
    begin
      wb(1'b0, `REG_VOLUME, 32'h0);
      i++;
    end
    while (q !== 32'h400A400A && i < 400);
    chk("ramp", q, 32'h400A400A);
    chk("keys", master_mute, 1'b0);
    req(32'h01000121, 32'h00020300, 16'h0001);
    chk("mute", {q[1:0], master_mute}, 3'b011);
    wb(1'b0, `REG_KEY_REPORT, 32'h0);
    chk("report", q, 32'h107);
    chk("report pin", key_report, 3'h7);
    req(32'h020181A1, 32'h00020300, 16'h0000);
    chk("get cur", q, 32'hF6000001);
    $display("volume test done");
    for (k = 0; k < 7; k++)
    begin
      req({8'h00, sif[k][7:0], 16'h0B01}, {28'h0, sif[k][11:8]}, 16'h0000);
      chk("alt", q[1], sif[k][12]);
    end
    wb(1'b0, `REG_STATE, 32'h0);
    chk("alt state", q, 32'h0012002F);
    chk("streams", {playback_stream_on, record_stream_on}, 2'b01);
    $display("interface test done");
    idle_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("awake", suspend_flag_n, 1'b1);
    i = 0;
    while (suspend_flag_n !== 1'b0 && i < 100)
    begin
      @(posedge core_clk);
      i++;
    end
    chk("asleep", suspend_flag_n, 1'b0);
    idle_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("wake", suspend_flag_n, 1'b1);
    $display("suspend test done");
    complete_run();
  end
endmodule // tb
